// ===== dp_port_ctrl.sv
// apb-driven controller for one port of a dual-port memory with semaphores
// How it works
// - hold address and select until the flag settles, then strobe write
// - slave mode: drive conflict input high, or low to block writes
// - only one master per width-expanded array; others are slaves
// - depth cascade: conflict indications are anded per port
// - semaphore access: memory select high, semaphore select low
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module dp_port_ctrl
  import dp_host_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory port pins
  input wire dp_pins_in_t pins_in,
  output dp_pins_out_t pins_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dp_pins_in_t pins_s;

  dp_sync #(
    .WIDTH($bits(dp_pins_in_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_in),
    .q(pins_s)
  );

  wire logic conflict_low = ~(&pins_s.port_conflict_flag_i);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] cfg_r;
  logic op_write_r;
  logic op_sem_r;
  logic done_r;
  logic conf_seen_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  dp_pins_out_t pins_r;
  dp_pins_out_t pins_nxt;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic setup_ph = psel & ~penable;
  wire logic wr_acc = psel & penable & pready & pwrite;
  wire logic mapped = hit(paddr, CTRL_OFS) | hit(paddr, ADDR_OFS) |
                      hit(paddr, WDATA_OFS) | hit(paddr, RDATA_OFS) |
                      hit(paddr, STATUS_OFS) | hit(paddr, CFG_OFS);
  wire logic busy = (state_r != ST_IDLE);
  // a start while busy is dropped; software polls busy first
  wire logic go = wr_acc & hit(paddr, CTRL_OFS) & pwdata[CTRL_GO_BIT] &
                  ~busy;
  wire logic wr_status = wr_acc & hit(paddr, STATUS_OFS);
  wire logic slave_mode = cfg_r[CFG_SLAVE_BIT];
  wire logic finish = (state_r == ST_HOLD || state_r == ST_READ) &&
                      (cnt_r == '0);
  wire logic conf_event = (state_r == ST_ARB) & conflict_low;

  wire logic [31:0] status_w = {28'h0000000, conflict_low, conf_seen_r,
                                done_r, busy};
  wire logic [31:0] rd_mux =
    hit(paddr, CTRL_OFS) ? {29'h0, op_sem_r, op_write_r, 1'b0} :
    hit(paddr, ADDR_OFS) ? {18'h0, addr_r} :
    hit(paddr, WDATA_OFS) ? {16'h0000, wdata_r} :
    hit(paddr, RDATA_OFS) ? {16'h0000, rdata_r} :
    hit(paddr, STATUS_OFS) ? status_w :
    hit(paddr, CFG_OFS) ? {30'h0, cfg_r} : 32'h00000000;

  // ----------------------------------------------------------------
  // apb response: zero wait states, registered
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata <= setup_ph ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= ADDR_RST;
      wdata_r <= DATA_RST;
      cfg_r <= CFG_RST;
      op_write_r <= 1'b0;
      op_sem_r <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, ADDR_OFS)) begin
        addr_r <= pwdata[ADDR_W-1:0];
      end
      if (wr_acc && hit(paddr, WDATA_OFS)) begin
        wdata_r <= pwdata[DATA_W-1:0];
      end
      if (wr_acc && hit(paddr, CFG_OFS)) begin
        cfg_r <= pwdata[1:0];
      end
      if (go) begin
        op_write_r <= pwdata[CTRL_WRITE_BIT];
        op_sem_r <= pwdata[CTRL_SEM_BIT];
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      conf_seen_r <= 1'b0;
    end else begin
      done_r <= finish | (done_r & ~(wr_status & pwdata[ST_DONE_BIT]));
      conf_seen_r <= conf_event |
                     (conf_seen_r & ~(wr_status & pwdata[ST_CONF_SEEN_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // port sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    pins_nxt = pins_r;
    pins_nxt.master_select = ~slave_mode;
    pins_nxt.port_conflict_flag_oe = slave_mode;
    pins_nxt.port_conflict_flag_o = ~cfg_r[CFG_INHIBIT_BIT];
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_SETUP;
          cnt_nxt = CNT_W'(SETTLE_CYC);
          pins_nxt.rw_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          if (pwdata[CTRL_SEM_BIT]) begin
            pins_nxt.addr = {{(ADDR_W-SEM_ADDR_W){1'b0}},
                             addr_r[SEM_ADDR_W-1:0]};
            pins_nxt.port_select_n = 1'b1;
            pins_nxt.semaphore_select_n = 1'b0;
            pins_nxt.data_o = {{(DATA_W-1){1'b0}}, wdata_r[0]};
          end else begin
            pins_nxt.addr = addr_r;
            pins_nxt.port_select_n = 1'b0;
            pins_nxt.semaphore_select_n = 1'b1;
            pins_nxt.data_o = wdata_r;
          end
          pins_nxt.data_oe = pwdata[CTRL_WRITE_BIT];
        end
      end
      ST_SETUP: begin
        // address and select held until the master flag has settled
        if (cnt_r == '0) begin
          if (op_write_r) begin
            state_nxt = ST_ARB;
          end else begin
            state_nxt = ST_READ;
            cnt_nxt = CNT_W'(RACCESS_CYC);
            pins_nxt.oe_n = 1'b0;
          end
        end
      end
      ST_ARB: begin
        // a master-mode memory write stalls while flagged; the other side's access ends it
        if (op_sem_r || slave_mode || !conflict_low) begin
          state_nxt = ST_STROBE;
          cnt_nxt = CNT_W'(WPULSE_CYC);
          pins_nxt.rw_n = 1'b0;
        end
      end
      ST_STROBE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_HOLD;
          cnt_nxt = CNT_W'(WHOLD_CYC);
          pins_nxt.rw_n = 1'b1;
        end
      end
      ST_HOLD, ST_READ: begin
        // dropping select and oe frees the semaphore read latch
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
          pins_nxt.port_select_n = 1'b1;
          pins_nxt.semaphore_select_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.data_oe = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      pins_r <= '{addr: ADDR_RST, port_select_n: 1'b1,
                  semaphore_select_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
                  data_o: DATA_RST, data_oe: 1'b0, master_select: 1'b1,
                  port_conflict_flag_o: 1'b1,
                  port_conflict_flag_oe: 1'b0};
      rdata_r <= DATA_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      if (state_r == ST_READ && cnt_r == '0) begin
        rdata_r <= pins_s.data_i;
      end
    end
  end

  assign pins_out = pins_r;

endmodule : dp_port_ctrl

// ===== dp_host_pkg.sv
// constants and carriers for the dual-port memory port controller
package dp_host_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] RDATA_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CFG_OFS = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_SEM_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_CONF_SEEN_BIT = 2;
  localparam int ST_CONF_NOW_BIT = 3;
  localparam int CFG_SLAVE_BIT = 0;
  localparam int CFG_INHIBIT_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int SEM_ADDR_W = 3;
  localparam int CASCADE_N = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [1:0] CFG_RST = 2'h0;

  // ----------------------------------------------------------------
  // timing: figures in ns, counts in pclk cycles
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int SETTLE_NS = 45;
  localparam int WPULSE_NS = 40;
  localparam int WHOLD_NS = 25;
  localparam int RACCESS_NS = 55;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS
                              + SYNC_STAGES;
  localparam int WPULSE_CYC = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHOLD_CYC = (WHOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RACCESS_CYC = (RACCESS_NS + CLK_NS - 1) / CLK_NS
                               + SYNC_STAGES;
  localparam int CNT_W = 5;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_ARB = 6'h04,
    ST_STROBE = 6'h08,
    ST_HOLD = 6'h10,
    ST_READ = 6'h20
  } seq_state_t;

  // ----------------------------------------------------------------
  // pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic port_select_n;
    logic semaphore_select_n;
    logic rw_n;
    logic oe_n;
    logic [DATA_W-1:0] data_o;
    logic data_oe;
    logic master_select;
    logic port_conflict_flag_o;
    logic port_conflict_flag_oe;
  } dp_pins_out_t;

  typedef struct packed {
    logic [DATA_W-1:0] data_i;
    logic [CASCADE_N-1:0] port_conflict_flag_i;
  } dp_pins_in_t;

endpackage : dp_host_pkg

// ===== dp_sync.sv
// two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module dp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : dp_sync

// ===== dp_port_ctrl_props.sv
// checker for the port controller's pin behaviour
`timescale 1ns/1ps
module dp_port_ctrl_props
  import dp_host_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory port pins
  input wire dp_pins_in_t pins_in,
  input wire dp_pins_out_t pins_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sel_any = !(pins_out.port_select_n && pins_out.semaphore_select_n);
  wire conf = !(&pins_in.port_conflict_flag_i);
  wire st_rd = psel && penable && pready && !pwrite && paddr == STATUS_OFS;
  // margin of four covers the two-flop sync on the flag
  sequence s_stall;
    (!pins_out.port_select_n && pins_out.master_select &&
     pins_out.rw_n && conf)[*4];
  endsequence
  sequence s_conf_held;
    conf[*5] ##1 st_rd;
  endsequence
  property p_settle;
    $fell(pins_out.rw_n) |-> sel_any && $past(sel_any, 9) &&
      $past(pins_out.addr, 9) == pins_out.addr;
  endproperty
  property p_stall;
    s_stall |=> pins_out.rw_n;
  endproperty
  property p_flag_dir;
    pins_out.port_conflict_flag_oe != pins_out.master_select;
  endproperty
  property p_and;
    s_conf_held |-> prdata[ST_CONF_NOW_BIT];
  endproperty
  property p_sem;
    !pins_out.semaphore_select_n |-> pins_out.port_select_n;
  endproperty
  a_settle: assert property (p_settle)
    else $error("write strobe before address and select settled");
  a_stall: assert property (p_stall)
    else $error("write strobe while the conflict flag is low");
  a_flag_dir: assert property (p_flag_dir)
    else $error("flag pin drive does not match configuration");
  a_and: assert property (p_and)
    else $error("combined conflict flag not reported");
  a_sem: assert property (p_sem)
    else $error("memory select low during semaphore access");
endmodule : dp_port_ctrl_props

bind dp_port_ctrl dp_port_ctrl_props chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
  .pins_out(pins_out)
);

// ===== dp_ram_model.sv
// behavioural dual-port memory with conflict flags and semaphores
`timescale 1ns/1ps
module dp_ram_model
  import dp_host_pkg::*;
(
  // left port, wired to the controller
  input wire dp_pins_out_t po,
  output logic [DATA_W-1:0] data_i,
  output logic flag_pin,
  // right port, driven by the bench
  input wire logic r_sel_n,
  input wire logic [ADDR_W-1:0] r_addr,
  input wire logic r_sem_go,
  input wire logic [2:0] r_sem_a,
  input wire logic r_sem_d,
  output logic r_sem_q
);
  // ------
  // state
  // ------
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [1:0] own [8] = '{default: 2'h0};
  logic [1:0] pend [8] = '{default: 2'h0};
  logic lbusy = 1'b0;
  logic rbusy = 1'b0;
  logic sem_q = 1'b1;
  logic [DATA_W-1:0] last = 16'h0000;
  wire match = !po.port_select_n && !r_sel_n && po.addr == r_addr;
  wire inh = po.master_select ? lbusy : !flag_pin;
  wire drv = !po.oe_n && po.rw_n &&
             (!po.port_select_n || !po.semaphore_select_n);
  assign flag_pin = po.master_select ? !lbusy :
    (po.port_conflict_flag_oe ? po.port_conflict_flag_o : 1'b1);
  // released pins show the inverse, so stale data never passes
  assign data_i = !drv ? ~last : po.semaphore_select_n ? mem[po.addr] :
    {DATA_W{sem_q}};
  assign r_sem_q = own[r_sem_a] != 2'h2;
  always @(data_i) if (drv) last = data_i;
  // inputs repeated inline: the wire may not have settled yet
  always @(po.port_select_n, po.addr) lbusy = !rbusy &&
    !po.port_select_n && !r_sel_n && po.addr == r_addr;
  always @(r_sel_n, r_addr) rbusy = !lbusy &&
    !po.port_select_n && !r_sel_n && po.addr == r_addr;
  always @(match) if (!match) {lbusy, rbusy} = 2'h0;
  task automatic sem_wr(input int s, input logic [2:0] a, input logic d);
    if (!d && own[a] == 2'h0) own[a] = 2'(s + 1);
    else if (!d && own[a] != 2'(s + 1)) pend[a][s] = 1'b1;
    else if (d && own[a] == 2'(s + 1)) begin
      own[a] = pend[a][1-s] ? 2'(2 - s) : 2'h0;
      pend[a] = 2'h0;
    end else if (d) pend[a][s] = 1'b0;
  endtask : sem_wr
  always @(negedge (po.semaphore_select_n | po.oe_n))
    sem_q = own[po.addr[2:0]] != 2'h1;
  always @(posedge po.rw_n) begin
    if (po.data_oe === 1'b1 && !po.port_select_n && !inh)
      mem[po.addr] = po.data_o;
    else if (po.data_oe === 1'b1 && !po.semaphore_select_n)
      sem_wr(0, po.addr[2:0], po.data_o[0]);
  end
  always @(posedge r_sem_go) sem_wr(1, r_sem_a, r_sem_d);
endmodule : dp_ram_model

// ===== dual_port_conflict_and_semaphores_bench.sv
// self-checking bench for the dual-port memory port controller
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, x); end end
module dual_port_conflict_and_semaphores_bench
  import dp_host_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic flag0, flag1, r_sel_n, r_sem_go, r_sem_d, r_sem_q;
  logic [ADDR_W-1:0] r_addr;
  logic [DATA_W-1:0] data_i;
  dp_pins_out_t po;
  dp_pins_in_t pins_in;
  int n_errors = 0;
  int checks = 0;
  // rows: {right side writes, value, left reads, right reads}
  logic [3:0] tbl [10] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hD, 4'h7, 4'hA,
                           4'hF, 4'h1, 4'h7};
  assign pins_in = {data_i, flag1, flag0};
  dp_port_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(po));
  dp_ram_model ram (.po(po), .data_i(data_i), .flag_pin(flag0),
    .r_sel_n(r_sel_n), .r_addr(r_addr), .r_sem_go(r_sem_go),
    .r_sem_a(3'h5), .r_sem_d(r_sem_d), .r_sem_q(r_sem_q));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: only the watchdog ends a wait for pready
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, CTRL_OFS, c);
    do apb(1'b0, STATUS_OFS, 32'h0);
    while (q[ST_DONE_BIT] !== 1'b1 && ++n < 100);
    `CHK(q[ST_DONE_BIT], 1'b1)
    apb(1'b1, STATUS_OFS, 32'h6);
  endtask : run
  task automatic access(input logic [31:0] c, input logic [13:0] a,
                        input logic [15:0] d);
    apb(1'b1, ADDR_OFS, {18'h0, a});
    apb(1'b1, WDATA_OFS, {16'h0, d});
    run(c);
  endtask : access
  // a read passes d as the expected word
  task automatic mem(input logic w, input logic [13:0] a,
                     input logic [15:0] d);
    access(w ? 32'h3 : 32'h1, a, d);
    if (!w) begin
      apb(1'b0, RDATA_OFS, 32'h0);
      `CHK(q, {16'h0, d})
    end
  endtask : mem
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // the conflict stall is unbounded, so a hang ends here
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, r_sem_go} = 5'h00;
    {flag1, r_sel_n, r_sem_d} = 3'h7;
    paddr = 8'h00;
    pwdata = 32'h0;
    r_addr = 14'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h40, 32'h3);
    `CHK(e, 1'b1)
    apb(1'b0, CFG_OFS, 32'h0);
    `CHK({po.master_select, q}, {1'b1, 32'h0})
    mem(1'b1, 14'h1ABC, 16'hA55A);
    mem(1'b0, 14'h1ABC, 16'hA55A);
    r_addr <= 14'h0123;
    r_sel_n <= 1'b0;
    // stalled write sets done only once released, so no run here
    apb(1'b1, ADDR_OFS, 32'h00000123);
    apb(1'b1, WDATA_OFS, 32'h00005AA5);
    apb(1'b1, CTRL_OFS, 32'h00000003);
    repeat (40) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[3:0], 4'hD)
    r_sel_n <= 1'b1;
    run(32'h0);
    mem(1'b0, 14'h0123, 16'h5AA5);
    r_addr <= 14'h0124;
    r_sel_n <= 1'b0;
    mem(1'b1, 14'h0123, 16'h0F0F);
    r_sel_n <= 1'b1;
    flag1 <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(q[ST_CONF_NOW_BIT], 1'b1)
    flag1 <= 1'b1;
    apb(1'b1, CFG_OFS, 32'h3);
    mem(1'b1, 14'h0123, 16'h1234);
    apb(1'b1, CFG_OFS, 32'h1);
    mem(1'b0, 14'h0123, 16'h0F0F);
    apb(1'b1, CFG_OFS, 32'h0);
    for (int i = 0; i < 10; i++) begin
      if (tbl[i][3]) begin
        r_sem_d <= tbl[i][2];
        @(posedge pclk);
        r_sem_go <= 1'b1;
        @(posedge pclk);
        r_sem_go <= 1'b0;
      end else access(32'h7, 14'h3FFD, {15'h0, tbl[i][2]});
      access(32'h5, 14'h3FFD, 16'h0);
      apb(1'b0, RDATA_OFS, 32'h0);
      `CHK(q, {16'h0, {16{tbl[i][1]}}})
      `CHK(r_sem_q, tbl[i][0])
    end
    final_report();
  end
endmodule : dual_port_conflict_and_semaphores_bench
